// file: src/freefall_wakeup_event_detector.sv
// Purpose: free-fall and wake-up event detector with APB registers
// Assumes: axis samples come from logic on pclk and stay valid between ticks
// Notes:   the sample tick is made here from the selected output rate
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "motion_event_params.svh"

module freefall_wakeup_event_detector #(
    parameter int STEP_FAST_CYCLES = `STEP_FAST_CYCLES,
    parameter int STEP_SLOW_CYCLES = `STEP_SLOW_CYCLES,
    parameter int ADDR_W           = 10
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire motion_event_pkg::axes_t samples,
    output logic                       motion_int,
    output logic                       irq,
    output logic                       sample_tick
);
    import motion_event_pkg::*;

    // ==========================================================
    // Parameter checks
    localparam int TW = $clog2(STEP_SLOW_CYCLES + 1);
    if (STEP_FAST_CYCLES < 1 || STEP_SLOW_CYCLES < STEP_FAST_CYCLES) begin : g_bad_step
        $error("step counts must be positive and slow not below fast");
    end
    if (ADDR_W < 10) begin : g_bad_addr
        $error("address too narrow for the register map");
    end

    // ==========================================================
    // State
    config_t    config_reg;
    threshold_t threshold_reg;
    logic [7:0] duration_reg;
    logic       sample_rate;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    source_t    source_reg;
    logic [7:0] duration_count;
    logic [TW-1:0] tick_count;

    config_t    next_config_reg;
    threshold_t next_threshold_reg;
    logic [7:0] next_duration_reg;
    logic       next_sample_rate;
    logic [7:0] next_irq_status;
    logic [7:0] next_irq_mask;
    source_t    next_source_reg;
    logic [7:0] next_duration_count;
    logic [TW-1:0] next_tick_count;
    logic [31:0] next_prdata;

    // ==========================================================
    // APB decode
    logic       setup_rd;
    logic       access_wr;
    logic [7:0] index;
    logic       mapped;
    logic [7:0] read_value;

    assign index     = paddr[9:2];
    assign setup_rd  = ce && psel && !penable && !pwrite;
    assign access_wr = ce && psel && penable && pwrite;
    assign pready    = ce;

    // Address bits above the register window must be zero
    logic upper_zero;
    if (ADDR_W > 10) begin : g_upper
        assign upper_zero = (paddr[ADDR_W-1:10] == '0);
    end else begin : g_no_upper
        assign upper_zero = 1'b1;
    end

    always_comb begin
        mapped     = (paddr[1:0] == 2'b00) && upper_zero;
        read_value = 8'h00;
        unique case (index)
            `IDX_CONFIG:     read_value = config_reg;
            `IDX_SOURCE:     read_value = source_reg;
            `IDX_THRESHOLD:  read_value = threshold_reg;
            `IDX_DURATION:   read_value = duration_reg;
            `IDX_RATE_CTRL:  read_value = {7'h00, sample_rate};
            `IDX_IRQ_STATUS: read_value = irq_status;
            `IDX_IRQ_MASK:   read_value = irq_mask;
            default:         mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    // ==========================================================
    // Sample tick; both rates step once per output sample
    logic [TW-1:0] period_last;
    assign period_last = sample_rate ? TW'(STEP_FAST_CYCLES - 1)
                                     : TW'(STEP_SLOW_CYCLES - 1);

    always_comb begin
        next_tick_count = tick_count + TW'(1);
        sample_tick     = 1'b0;
        // A rate change to a shorter period must not overrun it
        if (tick_count >= period_last) begin
            next_tick_count = '0;
            sample_tick     = ce;
        end
        if (!ce) begin
            next_tick_count = tick_count;
        end
    end

    // ==========================================================
    // Per-axis threshold compare
    logic [5:0] hit;
    logic [23:0] axis_flat;
    assign axis_flat = samples;

    for (genvar a = 0; a < 3; a++) begin : g_axis
        logic signed [7:0] value;
        logic [7:0]        magnitude;
        assign value     = axis_flat[8*a +: 8];
        assign magnitude = value[7] ? 8'(-value) : 8'(value);
        assign hit[2*a+1] = magnitude > {1'b0, threshold_reg.threshold_level};
        assign hit[2*a]   = magnitude < {1'b0, threshold_reg.threshold_level};
    end

    // ==========================================================
    // Event condition and duration counter
    logic [5:0] enabled_hit;
    logic       condition;
    logic       held;
    logic       evaluate;
    logic       confirm;

    assign enabled_hit = hit & config_reg.enables;
    assign condition   = config_reg.and_or_select
                       ? (config_reg.enables != 6'h00) && (enabled_hit == config_reg.enables)
                       : (enabled_hit != 6'h00);
    // Latched and confirmed: counter and flags wait for the host read
    assign held     = config_reg.latch_request_enable && source_reg.event_active_flag;
    assign evaluate = sample_tick && !held;
    assign confirm  = evaluate && condition && (duration_count >= duration_reg);

    always_comb begin
        next_duration_count = duration_count;
        if (evaluate) begin
            if (condition) begin
                // Saturate so a long event never wraps back below the limit
                if (duration_count < duration_reg) begin
                    next_duration_count = duration_count + 8'h01;
                end
            end else if (threshold_reg.counter_decrement_select) begin
                if (duration_count != 8'h00) begin
                    next_duration_count = duration_count - 8'h01;
                end
            end else begin
                next_duration_count = 8'h00;
            end
        end
    end

    // ==========================================================
    // Source register
    always_comb begin
        next_source_reg = source_reg;
        if (evaluate) begin
            if (confirm) begin
                next_source_reg.unused            = 1'b0;
                next_source_reg.event_active_flag = 1'b1;
                next_source_reg.flags             = enabled_hit;
            end else if (!config_reg.latch_request_enable) begin
                next_source_reg = '0;
            end
        end
        // A new event in the read cycle wins over the clear
        if (setup_rd && mapped && index == `IDX_SOURCE && !confirm) begin
            next_source_reg = '0;
        end
    end

    assign motion_int = source_reg.event_active_flag;

    // ==========================================================
    // Registers written by software
    always_comb begin
        next_config_reg    = config_reg;
        next_threshold_reg = threshold_reg;
        next_duration_reg  = duration_reg;
        next_sample_rate   = sample_rate;
        next_irq_mask      = irq_mask;
        if (access_wr && mapped) begin
            unique case (index)
                `IDX_CONFIG:    next_config_reg    = pwdata[7:0];
                `IDX_THRESHOLD: next_threshold_reg = pwdata[7:0];
                `IDX_DURATION:  next_duration_reg  = pwdata[7:0];
                `IDX_RATE_CTRL: next_sample_rate   = pwdata[0];
                `IDX_IRQ_MASK:  next_irq_mask      = pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Interrupt status: read clears, a new event wins
    logic new_event;
    assign new_event = confirm && !source_reg.event_active_flag;

    always_comb begin
        next_irq_status = irq_status;
        if (setup_rd && mapped && index == `IDX_IRQ_STATUS) begin
            next_irq_status = 8'h00;
        end
        if (new_event) begin
            next_irq_status[`IRQ_EVENT_BIT] = 1'b1;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // Read data is captured in the setup cycle, with the read clear
    // A read therefore needs ce high at its setup edge
    always_comb begin
        next_prdata = prdata;
        if (setup_rd) begin
            next_prdata = mapped ? {24'h000000, read_value} : 32'h00000000;
        end
    end

    // ==========================================================
    // Flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg    <= `CONFIG_RESET;
            threshold_reg <= `THRESHOLD_RESET;
            duration_reg  <= `DURATION_RESET;
            sample_rate   <= `RATE_RESET;
            irq_mask      <= `IRQ_MASK_RESET;
        end else if (ce) begin
            config_reg    <= next_config_reg;
            threshold_reg <= next_threshold_reg;
            duration_reg  <= next_duration_reg;
            sample_rate   <= next_sample_rate;
            irq_mask      <= next_irq_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_count <= '0;
        end else if (ce) begin
            tick_count <= next_tick_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duration_count <= 8'h00;
        end else if (ce) begin
            duration_count <= next_duration_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_reg <= '0;
        end else if (ce) begin
            source_reg <= next_source_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 8'h00;
        end else if (ce) begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce) begin
            prdata <= next_prdata;
        end
    end

endmodule : freefall_wakeup_event_detector

`default_nettype wire

// file: src/motion_event_params.svh
// Purpose: offsets, field positions, reset values and timing of the motion event detector
// Assumes: register index times four gives the APB byte address
// Notes:   definitions only
`ifndef MOTION_EVENT_PARAMS_SVH
`define MOTION_EVENT_PARAMS_SVH
// ==========================================================
// Register indices
`define IDX_CONFIG      8'h30
`define IDX_SOURCE      8'h31
`define IDX_THRESHOLD   8'h32
`define IDX_DURATION    8'h33
`define IDX_RATE_CTRL   8'h38
`define IDX_IRQ_STATUS  8'h39
`define IDX_IRQ_MASK    8'h3A
// ==========================================================
// Field positions and reset values
`define SRC_ACTIVE_BIT  6
`define IRQ_EVENT_BIT   0
`define CONFIG_RESET    8'h00
`define THRESHOLD_RESET 8'h02
`define DURATION_RESET  8'h00
`define RATE_RESET      1'b0
`define IRQ_MASK_RESET  8'h00
// ==========================================================
// Timing
`define CLK_HZ          200000000.0
`define STEP_FAST_MS    2.5
`define STEP_SLOW_MS    10.0
`define STEP_FAST_CYCLES ($rtoi(`STEP_FAST_MS * `CLK_HZ / 1000.0))
`define STEP_SLOW_CYCLES ($rtoi(`STEP_SLOW_MS * `CLK_HZ / 1000.0))
`endif

// file: src/motion_event_pkg.sv
// Purpose: types shared by the motion event detector and its bench
// Assumes: axis order z, y, x from high to low in every flag vector
// Notes:   flag vectors follow the source register layout
`default_nettype none
package motion_event_pkg;
    // ==========================================================
    // Samples
    typedef struct packed {
        logic signed [7:0] z;
        logic signed [7:0] y;
        logic signed [7:0] x;
    } axes_t;
    // ==========================================================
    // Registers
    typedef struct packed {
        logic       and_or_select;
        logic       latch_request_enable;
        logic [5:0] enables;
    } config_t;
    typedef struct packed {
        logic       counter_decrement_select;
        logic [6:0] threshold_level;
    } threshold_t;
    typedef struct packed {
        logic       unused;
        logic       event_active_flag;
        logic [5:0] flags;
    } source_t;
endpackage : motion_event_pkg
`default_nettype wire

// file: tb/apb_host_model.sv
// Purpose: host that reaches the detector registers over APB
// Assumes: one transfer at a time
// Notes:   waits on pready with no fixed latency
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
    end
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released write data does not keep the last value; paddr and pwrite keep theirs
        pwdata <= ~d;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: tb/freefall_wakeup_event_detector_tb.sv
// Purpose: self-checking bench of the motion event detector
// Assumes: tick periods shortened to 4 and 16 cycles
// Notes:   register table rows first, then event cases
`timescale 1ns/1ps
`default_nettype none
module freefall_wakeup_event_detector_tb;
    import motion_event_pkg::*;
    typedef struct {logic w; logic [9:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
    localparam int FAST_STEP = 4;
    localparam int SLOW_STEP = 16;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, motion_int, irq, sample_tick;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    axes_t       samples;
    int          n_fail = 0, n_compared = 0, cyc = 0, n;
    row_t rows [13] = '{'{0, 10'h0C0, 0, 32'h0, 0}, '{0, 10'h0C4, 0, 32'h0, 0}, '{0, 10'h0C8, 0, 32'h2, 0},
        '{0, 10'h0CC, 0, 32'h0, 0}, '{0, 10'h0E0, 0, 32'h0, 0}, '{0, 10'h0E8, 0, 32'h0, 0},
        '{1, 10'h0C0, 32'hFF, 0, 0}, '{0, 10'h0C0, 0, 32'hFF, 0}, '{1, 10'h0CC, 32'hA5, 0, 0},
        '{0, 10'h0CC, 0, 32'hA5, 0}, '{1, 10'h0C4, 32'hFF, 0, 0}, '{0, 10'h0C4, 0, 32'h0, 0},
        '{0, 10'h0D0, 0, 32'h0, 1}};
    apb_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    freefall_wakeup_event_detector #(.STEP_FAST_CYCLES(FAST_STEP), .STEP_SLOW_CYCLES(SLOW_STEP)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .samples(samples),
        .motion_int(motion_int), .irq(irq), .sample_tick(sample_tick));
    // ==========================================================
    // Tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rw(input logic w, input logic [9:0] a, input logic [31:0] d);
        i_host.xfer(w, a, d, rd, err);
    endtask : rw
    task ticks(input int k);
        repeat (k) @(negedge pclk iff sample_tick);
        @(posedge pclk);
    endtask : ticks
    // Cycles from one sample tick to the next, bounded
    task tick_gap(output int g);
        g = 1;
        @(negedge pclk iff sample_tick);
        @(negedge pclk);
        while (sample_tick !== 1'b1 && g < 100) begin
            @(negedge pclk);
            g++;
        end
    endtask : tick_gap
    // Counts ticks until the interrupt shows, bounded
    task until_int(output int c);
        c = 0;
        while (motion_int !== 1'b1 && c < 40) begin
            @(negedge pclk);
            if (sample_tick === 1'b1) c++;
        end
    endtask : until_int
    task do_reset;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // ==========================================================
    // Clock, timeout and sequence
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        samples = '0;
        do_reset();
        ce <= 1'b0;
        @(negedge pclk) chk({31'h0, pready}, 32'h0);
        @(posedge pclk) ce <= 1'b1;
        foreach (rows[i]) begin
            rw(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk(rd, rows[i].r);
            chk({31'h0, err}, {31'h0, rows[i].e});
        end
        // OR of x above and y above at the slow rate, only x hits
        samples <= '{z: 8'sh05, y: -8'sh10, x: 8'sh20};
        rw(1, 10'h0C8, 32'h10);
        rw(1, 10'h0CC, 32'h2);
        rw(1, 10'h0E8, 32'h1);
        tick_gap(n);
        chk(n, SLOW_STEP);
        rw(1, 10'h0C0, 32'h0A);
        until_int(n);
        chk(n, 3);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk) samples <= '0;
        rw(0, 10'h0C4, 0);
        chk(rd, 32'h42);
        rw(0, 10'h0E4, 0);
        chk(rd, 32'h1);
        chk({30'h0, motion_int, irq}, 32'h0);
        // Latched x below, duration zero, fast rate, after a second reset
        do_reset();
        rw(1, 10'h0E0, 32'h1);
        tick_gap(n);
        chk(n, FAST_STEP);
        rw(1, 10'h0C0, 32'h41);
        until_int(n);
        chk(n, 1);
        @(posedge pclk) samples <= '{z: 8'sh00, y: 8'sh00, x: 8'sh20};
        ticks(3);
        rw(0, 10'h0C4, 0);
        chk(rd, 32'h41);
        ticks(2);
        rw(0, 10'h0C4, 0);
        chk(rd, 32'h0);
        // Decrement mode: two hits, one miss, then three hits reach three
        do_reset();
        rw(1, 10'h0E0, 32'h1);
        rw(1, 10'h0C8, 32'h90);
        rw(1, 10'h0CC, 32'h3);
        rw(1, 10'h0C0, 32'h02);
        ticks(2);
        samples <= '0;
        ticks(1);
        samples <= '{z: 8'sh00, y: 8'sh00, x: 8'sh20};
        until_int(n);
        chk(n, 3);
        // AND of x and y above, latched, decrement mode; held counter confirms at once after the read
        @(posedge pclk);
        do_reset();
        rw(1, 10'h0E0, 32'h1);
        rw(1, 10'h0C8, 32'h90);
        rw(1, 10'h0CC, 32'h2);
        samples <= '{z: 8'sh00, y: 8'sh00, x: 8'sh20};
        rw(1, 10'h0C0, 32'hCA);
        ticks(4);
        chk({31'h0, motion_int}, 32'h0);
        samples <= '{z: 8'sh00, y: 8'sh20, x: 8'sh20};
        until_int(n);
        chk(n, 3);
        @(posedge pclk) samples <= '0;
        ticks(3);
        samples <= '{z: 8'sh00, y: 8'sh20, x: 8'sh20};
        rw(0, 10'h0C4, 0);
        chk(rd, 32'h4A);
        until_int(n);
        chk(n, 1);
        summarize();
    end
endmodule : freefall_wakeup_event_detector_tb
`default_nettype wire

// file: tb/motion_event_sva.sv
// Purpose: port checker of the motion event detector
// Assumes: sample tick period of at least four cycles
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module motion_event_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       ce,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [9:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       motion_int,
    input wire logic       irq,
    input wire logic       sample_tick
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Sequences
    sequence src_read_s;
        psel && !penable && !pwrite && ce && paddr == 10'h0C4 && !sample_tick;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // ==========================================================
    // Assertions
    a_ready_ce: assert property (pready == ce) else $error("pready differs from ce");
    a_read_clears: assert property (src_read_s |=> !motion_int)
        else $error("source read left interrupt set");
    a_int_on_tick: assert property ($rose(motion_int) |-> $past(sample_tick))
        else $error("interrupt rose without a tick");
    a_int_holds: assert property (!sample_tick && !(psel && !penable && !pwrite && ce && paddr == 10'h0C4)
        |=> $stable(motion_int)) else $error("interrupt moved between ticks");
    a_tick_gap: assert property (sample_tick && ce |=> !sample_tick [*3])
        else $error("ticks too close");
    a_err_unmapped: assert property (access_s and paddr == 10'h0D0 |-> pslverr)
        else $error("unmapped access without error");
    a_src_no_err: assert property (access_s and paddr == 10'h0C4 |-> !pslverr)
        else $error("source access flagged as error");
    a_irq_cause: assert property ($rose(irq) |-> $past(sample_tick || (psel && penable && pwrite)))
        else $error("irq rose without cause");
endmodule : motion_event_sva
bind freefall_wakeup_event_detector motion_event_sva i_sva (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .motion_int(motion_int), .irq(irq), .sample_tick(sample_tick));
`default_nettype wire
